//--- hw/uart_pkg.sv
package uart_pkg;

   // ----------------
   // register byte addresses
   // ----------------
   localparam logic [11:0] ADDR_DATA = 12'h000;
   localparam logic [11:0] ADDR_LINE_CONFIG = 12'h004;
   localparam logic [11:0] ADDR_MODEM_CONTROL = 12'h008;
   localparam logic [11:0] ADDR_LINE_STATUS = 12'h00c;
   localparam logic [11:0] ADDR_MODEM_INPUT_STATUS = 12'h010;

   // ----------------
   // modem control fields
   // ----------------
   localparam int MC_DTR = 0;
   localparam int MC_RTS = 1;
   localparam int MC_RX_ENABLE = 2;
   localparam int MC_MODE_LO = 3;
   localparam int MC_MODEM_IRQ_ENABLE = 5;
   localparam int MC_IRQ_MASTER_ENABLE = 6;
   localparam logic [7:0] MC_WRITE_MASK = 8'h7f;
   localparam logic [7:0] MC_RESET = 8'h00;

   // ----------------
   // line config fields
   // ----------------
   localparam int LC_LEN_LO = 0;
   localparam int LC_TWO_STOP = 2;
   localparam int LC_RX_PAR_EN = 3;
   localparam int LC_RX_PAR_ODD = 4;
   localparam int LC_TX_PAR_EN = 5;
   localparam int LC_TX_PAR_ODD = 6;
   localparam logic [6:0] LC_RESET = 7'h03;

   // ----------------
   // line status fields
   // ----------------
   localparam int LS_PARITY_ERROR = 0;
   localparam int LS_FRAMING_ERROR = 1;
   localparam int LS_OVERRUN = 2;
   localparam int LS_BREAK_RECEIVED = 3;
   localparam int LS_MODEM_CHANGE = 4;
   localparam int LS_TX_COMPLETE = 5;
   localparam int LS_TX_HOLDING_EMPTY = 6;
   localparam int LS_RX_DATA_READY = 7;
   localparam logic [7:0] LS_RESET = 8'h60;
   localparam logic [7:0] LS_IRQ_BITS = 8'h2f;

   // ----------------
   // modem input status fields
   // ----------------
   localparam int MS_CTS = 0;
   localparam int MS_DSR = 1;

   // ----------------
   // bit timing on the 16x baud tick
   // ----------------
   localparam logic [3:0] TICKS_HALF_BIT = 4'h7;
   localparam logic [3:0] TICKS_BIT_END = 4'hf;
   localparam logic [2:0] MIN_DATA_BITS_LAST = 3'h4;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_BREAK = 2'b01,
      MODE_ECHO = 2'b10,
      MODE_LOOP = 2'b11
   } mode_type;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PARITY = 3'b011,
      RX_STOP = 3'b100
   } rx_state_type;

   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PARITY = 3'b011,
      TX_STOP = 3'b100
   } tx_state_type;

endpackage

//--- hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
   import uart_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic pin,
   output logic level
);

   // ------------------------------------------------------------
   // three stage synchroniser with agreement filter
   // ------------------------------------------------------------
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } sync_state_type;

   sync_state_type sync_reg;
   sync_state_type sync_next;

   // output follows once stages two and three agree
   always_comb begin
      sync_next = sync_reg;
      sync_next.s1 = pin;
      sync_next.s2 = sync_reg.s1;
      sync_next.s3 = sync_reg.s2;
      if (sync_reg.s2 == sync_reg.s3) begin
         sync_next.out = sync_reg.s3;
      end
   end

   // lines idle high, so reset to one
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_reg <= 4'hf;
      end else if (clk_en) begin
         sync_reg <= sync_next;
      end
   end

   assign level = sync_reg.out;

endmodule // pin_sync
`default_nettype wire

//--- hw/uart_modem_status_interrupt.sv
// How it works
// - modem control read/write; one drives handshake low
// - master enable low holds interrupt low
// - four modes; break sends all-zero characters
// - echo copies input raw; holding transmit off
// - loop feeds transmitter into receiver, pin idle
// - receiver enable low blocks serial input
// - error flags set at stop; overrun on full
// - framing, parity and break detection per character
// - modem change flag; interrupt needs both enables
// - transmit complete flag raises interrupt if enabled
// - holding empty and ready on own pins
// - modem inputs read inverted, mask independent
// - clear to send gates new character start only
// - five to eight bits, lsb first, zero fill
// - bit clock from start; load and ready
// - holding keeps char; shared format; bit0 first
// - transmit parity independent of receive parity
// - modem change detector cleared by status read
// - status detector rising edge; read clears bits
// - reset sets transmit complete and pending edge
// - events during status read resolve at end
// - previous character kept; overrun on next
// - ready cleared by data read and reset
// - bit timing from sixteen times baud clock
`timescale 1ns/1ps
`default_nettype none
module uart_modem_status_interrupt
   import uart_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic CLK_EN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic BAUD16_CLK,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   input wire logic CTS_N,
   input wire logic DSR_N,
   output logic RTS_N,
   output logic DTR_N,
   output logic IRQ_OUT,
   output logic TX_HOLDING_EMPTY,
   output logic RX_DATA_READY
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] mc;
      logic [6:0] lc;
      logic [7:0] rx_hold;
      logic rx_full;
      logic [7:0] tx_hold;
      logic tx_full;
      logic [7:0] stat;
      logic usr_det, msr_det;
      logic [7:0] pend;
      logic pend_ms, baud_prev, cts_prev, dsr_prev, idle_prev;
      rx_state_type rx_st;
      logic [3:0] rx_cnt;
      logic [2:0] rx_idx;
      logic rx_stop2;
      logic [7:0] rx_sh;
      logic rx_par, rx_fe, rx_zero;
      tx_state_type tx_st;
      logic [3:0] tx_cnt;
      logic [2:0] tx_idx;
      logic tx_stop2;
      logic [7:0] tx_sh;
      logic tx_par, tx_line, tx_brk;
   } state_type;

   state_type state_reg;
   state_type state_next;

   logic serial_in_s, cts_n_s, dsr_n_s, baud_s, tick, modem_ev, rx_line, two_stop;
   logic [7:0] ev, rd_byte;
   logic [2:0] last_idx;
   mode_type mode;
   logic bus_setup, bus_done, rd_setup, rd_done, wr_done, addr_ok, tx_idle_now;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   pin_sync u_sync_rx (.clk(CLK_SYS), .arst_n(ARST_N), .clk_en(CLK_EN), .pin(SERIAL_IN), .level(serial_in_s));
   pin_sync u_sync_cts (.clk(CLK_SYS), .arst_n(ARST_N), .clk_en(CLK_EN), .pin(CTS_N), .level(cts_n_s));
   pin_sync u_sync_dsr (.clk(CLK_SYS), .arst_n(ARST_N), .clk_en(CLK_EN), .pin(DSR_N), .level(dsr_n_s));
   pin_sync u_sync_baud (.clk(CLK_SYS), .arst_n(ARST_N), .clk_en(CLK_EN), .pin(BAUD16_CLK), .level(baud_s));

   // ------------------------------------------------------------
   // bus decode and read mux
   // ------------------------------------------------------------
   assign mode = mode_type'(state_reg.mc[MC_MODE_LO +: 2]);
   assign tick = baud_s & ~state_reg.baud_prev;
   assign last_idx = MIN_DATA_BITS_LAST + {1'b0, state_reg.lc[LC_LEN_LO +: 2]};
   assign two_stop = state_reg.lc[LC_TWO_STOP];
   assign bus_setup = PSEL & ~PENABLE;
   assign bus_done = PSEL & PENABLE & CLK_EN;
   assign rd_setup = bus_setup & ~PWRITE;
   assign rd_done = bus_done & ~PWRITE;
   assign wr_done = bus_done & PWRITE;
   assign addr_ok = (PADDR == ADDR_DATA) || (PADDR == ADDR_LINE_CONFIG) || (PADDR == ADDR_MODEM_CONTROL)
      || (PADDR == ADDR_LINE_STATUS) || (PADDR == ADDR_MODEM_INPUT_STATUS);

   // register read data, unmapped reads zero
   always_comb begin
      rd_byte = 8'h00;
      unique case (PADDR)
         ADDR_DATA: rd_byte = state_reg.rx_hold;
         ADDR_LINE_CONFIG: rd_byte = {1'b0, state_reg.lc};
         ADDR_MODEM_CONTROL: rd_byte = state_reg.mc;
         ADDR_LINE_STATUS: rd_byte = state_reg.stat;
         ADDR_MODEM_INPUT_STATUS: rd_byte = {6'h00, ~dsr_n_s, ~cts_n_s};
         default: rd_byte = 8'h00;
      endcase
   end

   assign PRDATA = {24'h000000, rd_byte};
   assign PREADY = CLK_EN;
   assign PSLVERR = PSEL & PENABLE & ~addr_ok;

   // receiver source: loop takes transmitter, disable forces idle
   assign rx_line = ~state_reg.mc[MC_RX_ENABLE] ? 1'b1
      : (mode == MODE_LOOP) ? state_reg.tx_line : serial_in_s;

   assign modem_ev = (cts_n_s != state_reg.cts_prev) | (dsr_n_s != state_reg.dsr_prev);
   assign tx_idle_now = ~state_reg.tx_full & (state_reg.tx_st == TX_IDLE);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      ev = 8'h00;
      state_next.baud_prev = baud_s;
      state_next.cts_prev = cts_n_s;
      state_next.dsr_prev = dsr_n_s;
      state_next.idle_prev = tx_idle_now;

      // register writes
      if (wr_done) begin
         unique case (PADDR)
            ADDR_DATA: begin
               state_next.tx_hold = PWDATA[7:0];
               state_next.tx_full = 1'b1;
            end
            ADDR_LINE_CONFIG: state_next.lc = PWDATA[6:0];
            ADDR_MODEM_CONTROL: state_next.mc = PWDATA[7:0] & MC_WRITE_MASK;
            default: ;
         endcase
      end
      // data read frees the holding register
      if (rd_done && PADDR == ADDR_DATA) begin
         state_next.rx_full = 1'b0;
      end

      // receiver
      unique case (state_reg.rx_st)
         RX_IDLE: begin
            if (!rx_line) begin
               state_next.rx_st = RX_START;
               state_next.rx_cnt = 4'h0;
            end
         end
         RX_START: begin
            if (tick) begin
               state_next.rx_cnt = state_reg.rx_cnt + 4'h1;
               if (state_reg.rx_cnt == TICKS_HALF_BIT) begin
                  if (!rx_line) begin
                     state_next.rx_st = RX_DATA;
                     state_next.rx_cnt = 4'h0;
                     state_next.rx_idx = 3'h0;
                     state_next.rx_sh = 8'h00;
                     state_next.rx_par = 1'b0;
                     state_next.rx_zero = 1'b1;
                     state_next.rx_fe = 1'b0;
                     state_next.rx_stop2 = 1'b0;
                  end else begin
                     state_next.rx_st = RX_IDLE;
                  end
               end
            end
         end
         RX_DATA, RX_PARITY, RX_STOP: begin
            if (tick) begin
               state_next.rx_cnt = state_reg.rx_cnt + 4'h1;
               if (state_reg.rx_cnt == TICKS_BIT_END) begin
                  state_next.rx_zero = state_reg.rx_zero & ~rx_line;
                  if (state_reg.rx_st == RX_DATA) begin
                     state_next.rx_sh[state_reg.rx_idx] = rx_line;
                     state_next.rx_par = state_reg.rx_par ^ rx_line;
                     state_next.rx_idx = state_reg.rx_idx + 3'h1;
                     if (state_reg.rx_idx == last_idx) begin
                        state_next.rx_st = state_reg.lc[LC_RX_PAR_EN] ? RX_PARITY : RX_STOP;
                     end
                  end else if (state_reg.rx_st == RX_PARITY) begin
                     state_next.rx_par = state_reg.rx_par ^ rx_line;
                     state_next.rx_st = RX_STOP;
                  end else begin
                     state_next.rx_fe = state_reg.rx_fe | ~rx_line;
                     if (two_stop && !state_reg.rx_stop2) begin
                        state_next.rx_stop2 = 1'b1;
                     end else begin
                        // character complete: flags set during its stop bits
                        state_next.rx_st = RX_IDLE;
                        ev[LS_FRAMING_ERROR] = state_reg.rx_fe | ~rx_line;
                        ev[LS_PARITY_ERROR] = state_reg.lc[LC_RX_PAR_EN]
                           & (state_reg.rx_par ^ state_reg.lc[LC_RX_PAR_ODD]);
                        ev[LS_BREAK_RECEIVED] = state_reg.rx_zero & ~rx_line;
                        if (state_reg.rx_full && !(rd_done && PADDR == ADDR_DATA)) begin
                           ev[LS_OVERRUN] = 1'b1;
                        end else begin
                           state_next.rx_hold = state_reg.rx_sh;
                           state_next.rx_full = 1'b1;
                           ev[LS_RX_DATA_READY] = 1'b1;
                        end
                     end
                  end
               end
            end
         end
         default: state_next.rx_st = RX_IDLE;
      endcase

      // transmitter
      unique case (state_reg.tx_st)
         TX_IDLE: begin
            state_next.tx_line = 1'b1;
            if (state_reg.tx_full && !cts_n_s && mode != MODE_ECHO) begin
               state_next.tx_brk = (mode == MODE_BREAK);
               state_next.tx_sh = (mode == MODE_BREAK) ? 8'h00 : state_reg.tx_hold;
               state_next.tx_full = wr_done && PADDR == ADDR_DATA;
               state_next.tx_st = TX_START;
               state_next.tx_cnt = 4'h0;
               state_next.tx_idx = 3'h0;
               state_next.tx_par = 1'b0;
               state_next.tx_stop2 = 1'b0;
               state_next.tx_line = 1'b0;
            end
         end
         TX_START, TX_DATA, TX_PARITY, TX_STOP: begin
            if (tick) begin
               state_next.tx_cnt = state_reg.tx_cnt + 4'h1;
               if (state_reg.tx_cnt == TICKS_BIT_END) begin
                  unique case (state_reg.tx_st)
                     TX_START: begin
                        state_next.tx_st = TX_DATA;
                        state_next.tx_line = state_reg.tx_sh[0];
                     end
                     TX_DATA: begin
                        state_next.tx_par = state_reg.tx_par ^ state_reg.tx_line;
                        state_next.tx_sh = {1'b0, state_reg.tx_sh[7:1]};
                        state_next.tx_idx = state_reg.tx_idx + 3'h1;
                        state_next.tx_line = state_reg.tx_sh[1];
                        if (state_reg.tx_idx == last_idx) begin
                           if (state_reg.lc[LC_TX_PAR_EN]) begin
                              state_next.tx_st = TX_PARITY;
                              state_next.tx_line = ~state_reg.tx_brk
                                 & (state_reg.tx_par ^ state_reg.tx_line ^ state_reg.lc[LC_TX_PAR_ODD]);
                           end else begin
                              state_next.tx_st = TX_STOP;
                              state_next.tx_line = ~state_reg.tx_brk;
                           end
                        end
                     end
                     TX_PARITY: begin
                        state_next.tx_st = TX_STOP;
                        state_next.tx_line = ~state_reg.tx_brk;
                     end
                     TX_STOP: begin
                        if (two_stop && !state_reg.tx_stop2) begin
                           state_next.tx_stop2 = 1'b1;
                        end else begin
                           state_next.tx_st = TX_IDLE;
                           state_next.tx_line = 1'b1;
                        end
                     end
                     default: ;
                  endcase
               end
            end
         end
         default: state_next.tx_st = TX_IDLE;
      endcase

      // status events from levels
      ev[LS_MODEM_CHANGE] = modem_ev;
      ev[LS_TX_COMPLETE] = tx_idle_now & ~state_reg.idle_prev;
      ev[LS_TX_HOLDING_EMPTY] = ~state_reg.tx_full & state_next.tx_full == 1'b0 & state_reg.idle_prev
         ? 1'b0 : (state_reg.tx_full & ~state_next.tx_full);

      // line status: read clears, events during read resolve at its end
      if (rd_done && PADDR == ADDR_LINE_STATUS) begin
         state_next.stat = (state_reg.pend | ev) & ~state_reg.stat;
         state_next.usr_det = |((state_reg.pend | ev) & ~state_reg.stat & LS_IRQ_BITS);
         state_next.pend = 8'h00;
      end else if (rd_setup && PADDR == ADDR_LINE_STATUS) begin
         state_next.pend = ev;
      end else begin
         state_next.stat = state_reg.stat | ev;
         if (|(ev & ~state_reg.stat & LS_IRQ_BITS)) begin
            state_next.usr_det = 1'b1;
         end
      end

      // modem detector: read clears, same trailing-edge resolution
      if (rd_done && PADDR == ADDR_MODEM_INPUT_STATUS) begin
         state_next.msr_det = (state_reg.pend_ms | modem_ev) & ~state_reg.msr_det;
         state_next.pend_ms = 1'b0;
      end else if (rd_setup && PADDR == ADDR_MODEM_INPUT_STATUS) begin
         state_next.pend_ms = modem_ev;
      end else if (modem_ev) begin
         state_next.msr_det = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg <= '0;
         state_reg.mc <= MC_RESET;
         state_reg.lc <= LC_RESET;
         state_reg.stat <= LS_RESET;
         state_reg.usr_det <= 1'b1;
         state_reg.idle_prev <= 1'b1;
         state_reg.baud_prev <= 1'b1;
         state_reg.cts_prev <= 1'b1;
         state_reg.dsr_prev <= 1'b1;
         state_reg.tx_line <= 1'b1;
         state_reg.rx_st <= RX_IDLE;
         state_reg.tx_st <= TX_IDLE;
      end else if (CLK_EN) begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // echo is a raw copy, loop keeps the pin at mark
   assign SERIAL_OUT = (mode == MODE_ECHO) ? SERIAL_IN
      : (mode == MODE_LOOP) ? 1'b1 : state_reg.tx_line;
   assign RTS_N = ~state_reg.mc[MC_RTS];
   assign DTR_N = ~state_reg.mc[MC_DTR];
   assign IRQ_OUT = state_reg.mc[MC_IRQ_MASTER_ENABLE]
      & (state_reg.usr_det | (state_reg.mc[MC_MODEM_IRQ_ENABLE] & state_reg.msr_det));
   assign TX_HOLDING_EMPTY = ~state_reg.tx_full;
   assign RX_DATA_READY = state_reg.rx_full;

endmodule // uart_modem_status_interrupt
`default_nettype wire

//--- testbench/modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module modem_model (
   input wire logic clk,
   input wire logic serial_out,
   output var logic baud16,
   output var logic serial_in,
   output var logic cts_n,
   output var logic dsr_n
);
   logic [1:0] div = 2'h0;
   initial begin
      baud16 = 1'b0;
      serial_in = 1'b1;
      cts_n = 1'b1;
      dsr_n = 1'b1;
   end
   // 16x bit clock, one tick every 8 system cycles
   always @(posedge clk) begin
      div <= div + 2'h1;
      if (div == 2'h3) baud16 <= ~baud16;
   end
   // send one frame lsb first, stop level chosen by caller
   task send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int k = 0; k < 10; k++) begin
         serial_in <= f[k];
         repeat ((k == 9 && !stop) ? 12 : 16) @(posedge baud16); // short low stop: no false restart
      end
      serial_in <= 1'b1;
   endtask
   // capture eight data bits at their centres
   task get(output logic [7:0] d);
      int k;
      for (k = 0; k < 100000 && serial_out !== 1'b0; k++) @(posedge clk);
      repeat (8) @(posedge baud16);
      for (k = 0; k < 8; k++) begin
         repeat (16) @(posedge baud16);
         d[k] = serial_out;
      end
   endtask
   // handshake lines, clear to send low allows sending
   task set_lines(input logic c, input logic s);
      @(posedge clk);
      cts_n <= c;
      dsr_n <= s;
   endtask
endmodule // modem_model
`default_nettype wire

//--- testbench/uart_checker.sv
`timescale 1ns/1ps
`default_nettype none
module uart_checker
   import uart_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic SERIAL_IN,
   input wire logic SERIAL_OUT,
   input wire logic CTS_N,
   input wire logic DSR_N,
   input wire logic RTS_N,
   input wire logic DTR_N,
   input wire logic IRQ_OUT,
   input wire logic TX_HOLDING_EMPTY,
   input wire logic RX_DATA_READY
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);
   logic acc, mc_wr, rd_data;
   logic [7:0] mc;
   logic [3:0] stab;
   assign acc = PSEL && PENABLE && PREADY;
   assign mc_wr = acc && PWRITE && PADDR == ADDR_MODEM_CONTROL;
   assign rd_data = acc && !PWRITE && PADDR == ADDR_DATA;
   // shadow of modem control and age of the modem inputs
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         mc <= 8'h00;
         stab <= 4'h0;
      end else begin
         if (mc_wr) mc <= PWDATA[7:0];
         stab <= ($changed(CTS_N) || $changed(DSR_N)) ? 4'h0 : ((stab == 4'hf) ? stab : stab + 4'h1);
      end
   end
   a_irq_master_off: assert property (!mc[MC_IRQ_MASTER_ENABLE] |-> !IRQ_OUT) else $error("irq without master");
   a_handshake_pins: assert property (mc_wr |=> {RTS_N, DTR_N} == ~$past(PWDATA[1:0])) else $error("pins wrong");
   a_mc_readback: assert property (acc && !PWRITE && PADDR == ADDR_MODEM_CONTROL |-> PRDATA == {24'h0, mc & MC_WRITE_MASK})
      else $error("control readback wrong");
   a_echo_copy: assert property (mc[4:3] == MODE_ECHO |-> SERIAL_OUT == SERIAL_IN) else $error("echo wrong");
   a_loop_quiet: assert property (mc[4:3] == MODE_LOOP |-> SERIAL_OUT) else $error("loop output active");
   a_modem_image: assert property (acc && !PWRITE && PADDR == ADDR_MODEM_INPUT_STATUS && stab == 4'hf
      |-> PRDATA == {30'h0, !DSR_N, !CTS_N}) else $error("modem image wrong");
   a_ready_clear: assert property (rd_data |=> !RX_DATA_READY) else $error("ready not cleared");
   a_ready_hold: assert property ($fell(RX_DATA_READY) |-> $past(rd_data)) else $error("ready fell alone");
   a_reset_state: assert property ($rose(ARST_N) |-> TX_HOLDING_EMPTY && !RX_DATA_READY && RTS_N && DTR_N && !IRQ_OUT)
      else $error("reset state wrong");
   c_irq: cover property (mc[MC_IRQ_MASTER_ENABLE] && IRQ_OUT);
   c_echo: cover property (mc[4:3] == MODE_ECHO && !SERIAL_IN);
   c_ready: cover property ($rose(RX_DATA_READY));
endmodule // uart_checker
bind uart_modem_status_interrupt uart_checker uart_checker_inst (.CLK_SYS, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PWDATA, .PRDATA, .PREADY, .SERIAL_IN, .SERIAL_OUT, .CTS_N, .DSR_N, .RTS_N, .DTR_N, .IRQ_OUT, .TX_HOLDING_EMPTY,
   .RX_DATA_READY);
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import uart_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ok;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, baud, sin, sout, cts_n, dsr_n, rts_n, dtr_n, irq, the, rdr;
   logic [7:0] b, got;
   int fail_count = 0, n_checks = 0, seed = 32'hbd1c912f, i;
   always #4 clk = ~clk;
   uart_modem_status_interrupt uart_modem_status_interrupt_inst (.CLK_SYS(clk), .ARST_N(arst_n), .CLK_EN(1'b1),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .BAUD16_CLK(baud), .SERIAL_IN(sin), .SERIAL_OUT(sout), .CTS_N(cts_n),
      .DSR_N(dsr_n), .RTS_N(rts_n), .DTR_N(dtr_n), .IRQ_OUT(irq), .TX_HOLDING_EMPTY(the), .RX_DATA_READY(rdr));
   modem_model modem_model_inst (.clk(clk), .serial_out(sout), .baud16(baud), .serial_in(sin), .cts_n(cts_n),
      .dsr_n(dsr_n));
   // verdict and end of run
   task complete_run();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one apb transfer, request held until pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(negedge clk);
         rd = prdata;
         ok = pready;
         @(posedge clk);
         if (ok === 1'b1) break;
      end
      if (k == 100) begin
         fail_count++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task wait_rdr();
      int k;
      for (k = 0; k < 3000 && rdr !== 1'b1; k++) @(posedge clk);
      if (k == 3000) begin
         fail_count++;
         complete_run();
      end
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rdc(ADDR_LINE_STATUS, 32'h60);
      for (i = 0; i < 4; i++) begin
         b = 8'($random(seed)) & 8'h67;
         apb(1'b1, ADDR_MODEM_CONTROL, {24'h0, b});
         chk({rts_n, dtr_n}, {30'h0, ~b[1:0]});
         rdc(ADDR_MODEM_CONTROL, {24'h0, b});
         modem_model_inst.set_lines(i[0], i[1]);
         repeat (20) @(posedge clk);
         rdc(ADDR_MODEM_INPUT_STATUS, {30'h0, !i[1], !i[0]});
      end
      rdc(ADDR_LINE_STATUS, 32'h10);
      apb(1'b1, ADDR_MODEM_CONTROL, 32'h64);
      chk(irq, 1'b0);
      modem_model_inst.set_lines(1'b1, 1'b0);
      repeat (20) @(posedge clk);
      chk(irq, 1'b1);
      apb(1'b0, ADDR_MODEM_INPUT_STATUS, 32'h0);
      chk(irq, 1'b0);
      apb(1'b1, ADDR_MODEM_CONTROL, 32'h44);
      modem_model_inst.set_lines(1'b0, 1'b1);
      repeat (20) @(posedge clk);
      chk(irq, 1'b0);
      apb(1'b0, ADDR_LINE_STATUS, 32'h0);
      b = 8'($random(seed));
      fork modem_model_inst.get(got); apb(1'b1, ADDR_DATA, {24'h0, b}); join
      chk(got, b);
      repeat (300) @(posedge clk);
      chk(irq, 1'b1);
      rdc(ADDR_LINE_STATUS, 32'h60);
      chk({irq, the}, 2'b01);
      apb(1'b1, ADDR_MODEM_CONTROL, 32'h4c);
      fork modem_model_inst.get(got); apb(1'b1, ADDR_DATA, 32'hff); join
      chk(got, 8'h00);
      repeat (300) @(posedge clk);
      apb(1'b1, ADDR_MODEM_CONTROL, 32'h44);
      modem_model_inst.set_lines(1'b1, 1'b1);
      repeat (20) @(posedge clk);
      apb(1'b1, ADDR_DATA, {24'h0, b});
      ok = 1'b1;
      repeat (400) begin
         @(posedge clk);
         ok &= sout;
      end
      chk({ok, the}, 2'b10);
      fork modem_model_inst.get(got); modem_model_inst.set_lines(1'b0, 1'b1); join
      chk(got, b);
      repeat (300) @(posedge clk);
      apb(1'b0, ADDR_LINE_STATUS, 32'h0);
      for (i = 0; i < 3; i++) begin
         b = 8'($random(seed));
         modem_model_inst.send(b, 1'b1);
         wait_rdr();
         rdc(ADDR_DATA, {24'h0, b});
         chk(rdr, 1'b0);
      end
      modem_model_inst.send(8'h3c, 1'b1);
      modem_model_inst.send(8'hc3, 1'b1);
      repeat (50) @(posedge clk);
      rdc(ADDR_LINE_STATUS, 32'h84);
      rdc(ADDR_DATA, 32'h3c);
      for (i = 0; i < 2; i++) begin
         apb(1'b0, ADDR_LINE_STATUS, 32'h0);
         modem_model_inst.send(i ? 8'h00 : 8'h5a, 1'b0);
         repeat (50) @(posedge clk);
         rdc(ADDR_LINE_STATUS, i ? 32'h8a : 32'h82);
         rdc(ADDR_DATA, i ? 32'h0 : 32'h5a);
      end
      apb(1'b1, ADDR_MODEM_CONTROL, 32'h40);
      modem_model_inst.send(8'h55, 1'b1);
      repeat (50) @(posedge clk);
      chk(rdr, 1'b0);
      apb(1'b1, ADDR_MODEM_CONTROL, 32'h1c);
      b = 8'($random(seed));
      apb(1'b1, ADDR_DATA, {24'h0, b});
      wait_rdr();
      rdc(ADDR_DATA, {24'h0, b});
      apb(1'b1, ADDR_MODEM_CONTROL, 32'h14);
      apb(1'b1, ADDR_DATA, 32'h0f);
      modem_model_inst.send(8'h96, 1'b1);
      chk(the, 1'b0);
      complete_run();
   end
endmodule // tb
`default_nettype wire
